// ==== pkg/gpev_pkg.sv ====
// constants, state encoding and register map of the gpio event and logic-function block
// Behaviour
// - eight interrupt-source bits, reset zero, set when an unmasked io raises its event
// - writing one to an interrupt-source bit clears it and its event bit
// - interrupt pin held low while any interrupt-source bit is set
// - eight event bits, reset zero, set on the edge each io selects
// - writing one to an event bit clears it and its interrupt-source bit
// - changing an io's edge selection clears its event and interrupt-source bits
// - upper two-to-one mode drives io6 from table zero bits 7:4 indexed by io5, io4
// - lower three-to-one mode drives io2 from table one; upper three-to-one drives io7 from it
// - upper field 00 normal, 01 two-to-one, 10 three-to-one, 11 reserved
package gpev_pkg;
	// register offsets on the serial port
	localparam logic [7:0] OFS_IRQ_SRC  = 8'h08;
	localparam logic [7:0] OFS_EVENT    = 8'h09;
	localparam logic [7:0] OFS_FN_MODE  = 8'h10;
	localparam logic [7:0] OFS_TABLE0   = 8'h11;
	localparam logic [7:0] OFS_TABLE1   = 8'h12;
	// values after reset
	localparam logic [7:0] RST_IRQ_SRC  = 8'h00;
	localparam logic [7:0] RST_EVENT    = 8'h00;
	localparam logic [7:0] RST_FN_MODE  = 8'h00;
	localparam logic [7:0] RST_TABLE0   = 8'h00;
	localparam logic [7:0] RST_TABLE1   = 8'h00;
	// field positions in logic_fn_mode
	localparam int UPPER_SEL_LSB = 4;
	localparam int LOWER_SEL_LSB = 0;
	// upper and lower field codes
	localparam logic [1:0] FN_NORMAL   = 2'h0;
	localparam logic [1:0] FN_TWO_ONE  = 2'h1;
	localparam logic [1:0] FN_THREE_ONE = 2'h2;
	// edge selection codes per io
	localparam logic [1:0] EDGE_NONE    = 2'h0;
	localparam logic [1:0] EDGE_RISE    = 2'h1;
	localparam logic [1:0] EDGE_FALL    = 2'h2;
	localparam logic [1:0] EDGE_BOTH    = 2'h3;
	// serial port count value of the last bit in a byte
	localparam logic [3:0] BITS_LAST    = 4'h7;
	// serial slave states, one-hot
	typedef enum logic [5:0] {
		SS_IDLE  = 6'h01,
		SS_RX    = 6'h02,
		SS_ACKD  = 6'h04,
		SS_ACK   = 6'h08,
		SS_TX    = 6'h10,
		SS_TXACK = 6'h20
	} gpev_ss_type;
endpackage : gpev_pkg

// ==== logic/gpev_top.sv ====
// gpio event flags, open-drain interrupt, lookup-table outputs and serial register port
module gpev_top #(
	parameter logic [6:0] DEV_ADDR = 7'h20
) (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        scl_line,
	input  wire logic        sda_line,
	output logic             sda_drv,
	output logic             sda_oe,
	input  wire logic [7:0]  io_pin,
	input  wire logic [15:0] edge_select_cfg,
	input  wire logic [7:0]  irq_mask,
	output logic             irq_out_n_drv,
	output logic             irq_out_n_oe,
	output logic [7:0]       pld_out,
	output logic [7:0]       pld_oe
);
	typedef struct packed {
		logic [2:0]           scl_s;
		logic [2:0]           sda_s;
		logic                 scl_l;
		logic                 sda_l;
		logic [7:0]           io_s1;
		logic [7:0]           io_s2;
		logic [7:0]           io_s3;
		logic [7:0]           io_l;
		logic [15:0]          sense_prev;
		logic [7:0]           src;
		logic [7:0]           evt;
		logic [7:0]           mode;
		logic [7:0]           tab0;
		logic [7:0]           tab1;
		logic [7:0]           ptr;
		logic [7:0]           shreg;
		logic [3:0]           cnt;
		gpev_pkg::gpev_ss_type fsm;
		logic                 addr_phase;
		logic                 have_ptr;
		logic                 rw;
		logic                 acked;
		logic                 sda_oe;
		logic                 irq_oe;
		logic [7:0]           pld_out;
		logic [7:0]           pld_oe;
	} gpev_state_type;

	gpev_state_type st_ff;
	gpev_state_type nxt_st;
	logic [1:0]     rst_sync_ff;
	logic           rst_n;
	logic           scl_new;
	logic           sda_new;
	logic           scl_rise;
	logic           scl_fall;
	logic           bus_start;
	logic           bus_stop;
	logic           bus_wr;
	logic [7:0]     wr_data;
	logic [7:0]     rx_byte;
	logic [7:0]     rd_val;
	logic [7:0]     io_new;
	logic [7:0]     io_rise;
	logic [7:0]     io_fall;
	logic [7:0]     ev_set;
	logic [7:0]     src_set;
	logic [7:0]     sense_chg;
	logic [7:0]     clr_bits;
	logic [1:0]     upper_half_logic_sel;
	logic [1:0]     lower_half_logic_sel;

	// reset released through two flops so every flop leaves reset on the same edge
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// pin levels count only once the second and third sync stages agree
	assign scl_new   = (st_ff.scl_s[1] == st_ff.scl_s[2]) ? st_ff.scl_s[2] : st_ff.scl_l;
	assign sda_new   = (st_ff.sda_s[1] == st_ff.sda_s[2]) ? st_ff.sda_s[2] : st_ff.sda_l;
	assign scl_rise  = !st_ff.scl_l && scl_new;
	assign scl_fall  = st_ff.scl_l && !scl_new;
	assign bus_start = st_ff.scl_l && scl_new && st_ff.sda_l && !sda_new;
	assign bus_stop  = st_ff.scl_l && scl_new && !st_ff.sda_l && sda_new;
	assign rx_byte   = {st_ff.shreg[6:0], sda_new};
	assign io_new    = ((st_ff.io_s2 ~^ st_ff.io_s3) & st_ff.io_s3)
			| ((st_ff.io_s2 ^ st_ff.io_s3) & st_ff.io_l);
	assign io_rise   = ~st_ff.io_l & io_new;
	assign io_fall   = st_ff.io_l & ~io_new;

	// per-io edge qualification and detection of a changed edge selection
	for (genvar i = 0; i < 8; i++) begin : g_io
		always_comb begin
			case (edge_select_cfg[2*i+1:2*i])
				gpev_pkg::EDGE_RISE: ev_set[i] = io_rise[i];
				gpev_pkg::EDGE_FALL: ev_set[i] = io_fall[i];
				gpev_pkg::EDGE_BOTH: ev_set[i] = io_rise[i] | io_fall[i];
				default:             ev_set[i] = 1'b0;
			endcase
		end
		assign sense_chg[i] = edge_select_cfg[2*i+1:2*i] != st_ff.sense_prev[2*i+1:2*i];
	end

	// masked ios still log events but never raise an interrupt source
	assign src_set = ev_set & ~irq_mask;

	// register read mux; unmapped offsets read as zero
	function automatic logic [7:0] rd_reg(input gpev_state_type s);
		case (s.ptr)
			gpev_pkg::OFS_IRQ_SRC: rd_reg = s.src;
			gpev_pkg::OFS_EVENT:   rd_reg = s.evt;
			gpev_pkg::OFS_FN_MODE: rd_reg = s.mode;
			gpev_pkg::OFS_TABLE0:  rd_reg = s.tab0;
			gpev_pkg::OFS_TABLE1:  rd_reg = s.tab1;
			default:               rd_reg = 8'h00;
		endcase
	endfunction : rd_reg

	// read value of the current pointer, loaded into the shifter at each byte start
	assign rd_val = rd_reg(st_ff);

	// serial slave: address, pointer byte, then auto-incrementing data bytes
	always_comb begin
		nxt_st = st_ff;
		bus_wr = 1'b0;
		wr_data = rx_byte;
		nxt_st.scl_s = {st_ff.scl_s[1:0], scl_line};
		nxt_st.sda_s = {st_ff.sda_s[1:0], sda_line};
		nxt_st.scl_l = scl_new;
		nxt_st.sda_l = sda_new;
		if (bus_start) begin
			nxt_st.fsm = gpev_pkg::SS_RX;
			nxt_st.cnt = 4'h0;
			nxt_st.addr_phase = 1'b1;
			nxt_st.have_ptr = 1'b0;
			nxt_st.sda_oe = 1'b0;
		end else if (bus_stop) begin
			nxt_st.fsm = gpev_pkg::SS_IDLE;
			nxt_st.sda_oe = 1'b0;
		end else begin
			case (st_ff.fsm)
				gpev_pkg::SS_IDLE: begin
					nxt_st.sda_oe = 1'b0;
				end
				gpev_pkg::SS_RX: begin
					if (scl_rise) begin
						nxt_st.shreg = rx_byte;
						nxt_st.cnt = st_ff.cnt + 4'h1;
						if (st_ff.cnt == gpev_pkg::BITS_LAST) begin
							nxt_st.fsm = gpev_pkg::SS_ACKD;
							if (st_ff.addr_phase) begin
								nxt_st.addr_phase = 1'b0;
								nxt_st.rw = rx_byte[0];
								if (rx_byte[7:1] != DEV_ADDR) begin
									nxt_st.fsm = gpev_pkg::SS_IDLE;
								end
							end else if (!st_ff.have_ptr) begin
								nxt_st.ptr = rx_byte;
								nxt_st.have_ptr = 1'b1;
							end else begin
								bus_wr = 1'b1;
								nxt_st.ptr = st_ff.ptr + 8'h01;
							end
						end
					end
				end
				gpev_pkg::SS_ACKD: begin
					if (scl_fall) begin
						nxt_st.sda_oe = 1'b1;
						nxt_st.fsm = gpev_pkg::SS_ACK;
					end
				end
				gpev_pkg::SS_ACK: begin
					if (scl_fall) begin
						nxt_st.cnt = 4'h0;
						nxt_st.sda_oe = 1'b0;
						nxt_st.fsm = gpev_pkg::SS_RX;
						if (st_ff.rw) begin
							nxt_st.shreg = rd_val;
							nxt_st.sda_oe = !rd_val[7];
							nxt_st.ptr = st_ff.ptr + 8'h01;
							nxt_st.fsm = gpev_pkg::SS_TX;
						end
					end
				end
				gpev_pkg::SS_TX: begin
					if (scl_fall) begin
						nxt_st.cnt = st_ff.cnt + 4'h1;
						nxt_st.shreg = {st_ff.shreg[6:0], 1'b0};
						nxt_st.sda_oe = !st_ff.shreg[6];
						if (st_ff.cnt == gpev_pkg::BITS_LAST) begin
							nxt_st.sda_oe = 1'b0; // free the line for the master's ack
							nxt_st.fsm = gpev_pkg::SS_TXACK;
						end
					end
				end
				gpev_pkg::SS_TXACK: begin
					if (scl_rise) begin
						nxt_st.acked = !sda_new;
					end
					if (scl_fall) begin
						nxt_st.fsm = gpev_pkg::SS_IDLE;
						if (st_ff.acked) begin
							nxt_st.cnt = 4'h0;
							nxt_st.shreg = rd_val;
							nxt_st.sda_oe = !rd_val[7];
							nxt_st.ptr = st_ff.ptr + 8'h01;
							nxt_st.fsm = gpev_pkg::SS_TX;
						end
					end
				end
				default: begin
					nxt_st.fsm = gpev_pkg::SS_IDLE;
					nxt_st.sda_oe = 1'b0;
				end
			endcase
		end

		// plain register writes; reserved mode bits are stored as written
		if (bus_wr) begin
			case (st_ff.ptr)
				gpev_pkg::OFS_FN_MODE: nxt_st.mode = wr_data;
				gpev_pkg::OFS_TABLE0:  nxt_st.tab0 = wr_data;
				gpev_pkg::OFS_TABLE1:  nxt_st.tab1 = wr_data;
				default: ;
			endcase
		end

		// io sync and flag update; a new edge wins over a clear in the same cycle
		nxt_st.io_s1 = io_pin;
		nxt_st.io_s2 = st_ff.io_s1;
		nxt_st.io_s3 = st_ff.io_s2;
		nxt_st.io_l = io_new;
		nxt_st.sense_prev = edge_select_cfg;
		clr_bits = sense_chg;
		if (bus_wr && (st_ff.ptr == gpev_pkg::OFS_IRQ_SRC || st_ff.ptr == gpev_pkg::OFS_EVENT)) begin
			clr_bits = clr_bits | wr_data;
		end
		nxt_st.src = (st_ff.src & ~clr_bits) | src_set;
		nxt_st.evt = (st_ff.evt & ~clr_bits) | ev_set;
		nxt_st.irq_oe = |nxt_st.src;

		// lookup-table outputs, refreshed from the filtered io levels
		nxt_st.pld_out = 8'h00;
		nxt_st.pld_oe = 8'h00;
		case (upper_half_logic_sel)
			gpev_pkg::FN_TWO_ONE: begin
				nxt_st.pld_oe[6] = 1'b1;
				nxt_st.pld_out[6] = st_ff.tab0[{1'b1, st_ff.io_l[5:4]}];
			end
			gpev_pkg::FN_THREE_ONE: begin
				nxt_st.pld_oe[7] = 1'b1;
				nxt_st.pld_out[7] = st_ff.tab1[st_ff.io_l[6:4]];
			end
			default: ; // normal gpio, and the reserved code behaves the same
		endcase
		if (lower_half_logic_sel == gpev_pkg::FN_THREE_ONE) begin
			nxt_st.pld_oe[2] = 1'b1;
			nxt_st.pld_out[2] = st_ff.tab1[{st_ff.io_l[3], st_ff.io_l[1:0]}];
		end
	end

	assign upper_half_logic_sel = st_ff.mode[gpev_pkg::UPPER_SEL_LSB +: 2];
	assign lower_half_logic_sel = st_ff.mode[gpev_pkg::LOWER_SEL_LSB +: 2];

	// state register; fsm has a non-zero idle code so it is set after the clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.fsm <= gpev_pkg::SS_IDLE;
			st_ff.scl_l <= 1'b1;
			st_ff.sda_l <= 1'b1;
			// sync stages start at the idle bus level so no false edge follows reset
			st_ff.scl_s <= 3'h7;
			st_ff.sda_s <= 3'h7;
			st_ff.src <= gpev_pkg::RST_IRQ_SRC;
			st_ff.evt <= gpev_pkg::RST_EVENT;
			st_ff.mode <= gpev_pkg::RST_FN_MODE;
			st_ff.tab0 <= gpev_pkg::RST_TABLE0;
			st_ff.tab1 <= gpev_pkg::RST_TABLE1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// open-drain lines only ever pull low
	assign sda_drv       = 1'b0;
	assign sda_oe        = st_ff.sda_oe;
	assign irq_out_n_drv = 1'b0;
	assign irq_out_n_oe  = st_ff.irq_oe;
	assign pld_out       = st_ff.pld_out;
	assign pld_oe        = st_ff.pld_oe;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	chk_irq_pin_level: assert property (irq_out_n_oe == (|st_ff.src))
		else $error("interrupt pin does not track source flags");
	chk_src_mask_gate: assert property (
			(st_ff.src & ~$past(st_ff.src) & $past(irq_mask)) == 8'h00)
		else $error("masked io raised an interrupt source");
	chk_src_with_event: assert property (
			((st_ff.src & ~$past(st_ff.src)) & ~st_ff.evt) == 8'h00)
		else $error("interrupt source set without event");
	chk_src_w1c_clear: assert property (bus_wr && st_ff.ptr == gpev_pkg::OFS_IRQ_SRC
			|=> ((st_ff.src | st_ff.evt) & $past(wr_data) & ~$past(ev_set)) == 8'h00)
		else $error("write one to source did not clear both flags");
	chk_evt_w1c_clear: assert property (bus_wr && st_ff.ptr == gpev_pkg::OFS_EVENT
			|=> ((st_ff.src | st_ff.evt) & $past(wr_data) & ~$past(ev_set)) == 8'h00)
		else $error("write one to event did not clear both flags");
	chk_sense_chg_clr: assert property (sense_chg != 8'h00
			|=> ((st_ff.src | st_ff.evt) & $past(sense_chg) & ~$past(ev_set)) == 8'h00)
		else $error("edge selection change left flags set");
	chk_edge_sets_evt: assert property (ev_set != 8'h00
			|=> (st_ff.evt & $past(ev_set)) == $past(ev_set))
		else $error("selected edge did not set event flag");
	chk_upper_two_one: assert property (upper_half_logic_sel == gpev_pkg::FN_TWO_ONE
			|=> pld_oe[6] && pld_out[6] == $past(st_ff.tab0[{1'b1, st_ff.io_l[5:4]}]))
		else $error("io6 not driven from table zero");
	chk_upper_normal: assert property (upper_half_logic_sel == gpev_pkg::FN_NORMAL
			|=> !pld_oe[6] && !pld_oe[7])
		else $error("upper ios driven in normal mode");
	chk_lower_three_one: assert property (lower_half_logic_sel != gpev_pkg::FN_THREE_ONE
			|=> !pld_oe[2])
		else $error("io2 driven outside three-to-one mode");
	chk_lower_io2_drive: assert property (lower_half_logic_sel == gpev_pkg::FN_THREE_ONE
			|=> pld_oe[2]
			&& pld_out[2] == $past(st_ff.tab1[{st_ff.io_l[3], st_ff.io_l[1:0]}]))
		else $error("io2 not driven from table one");
endmodule : gpev_top

// ==== verification/gpev_i2c_host.sv ====
// i2c bus master model that plays the host at the serial register port
module gpev_i2c_host #(
	parameter logic [6:0] DEV_ADDR = 7'h20
) (
	input  wire logic mclk,
	input  wire logic sda_in,
	output logic      scl_line,
	output logic      sda_low
);
	timeunit 1ns;
	timeprecision 1ns;
	int ack_misses = 0;
	// bus idles released; scl driven high, the pull-up keeps sda high
	initial begin
		scl_line = 1'b1;
		sda_low  = 1'b0;
	end
	// third of a bit; longer than the 3-4 cycle pin filter so every level is seen
	task automatic tick;
		repeat (6) @(posedge mclk);
	endtask : tick
	// data only moves while scl is low, so no false start or stop
	task automatic put_bit(input logic b);
		sda_low <= ~b;
		tick();
		scl_line <= 1'b1;
		tick();
		scl_line <= 1'b0;
		tick();
	endtask : put_bit
	task automatic get_bit(output logic b);
		sda_low <= 1'b0;
		tick();
		scl_line <= 1'b1;
		tick();
		b = sda_in;
		scl_line <= 1'b0;
		tick();
	endtask : get_bit
	task automatic send_byte(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i]);
		end
		get_bit(a);
		if (a !== 1'b0) begin
			ack_misses++;
		end
	endtask : send_byte
	// also serves as repeated start: sda released before scl rises
	task automatic start_cond;
		sda_low <= 1'b0;
		tick();
		scl_line <= 1'b1;
		tick();
		sda_low <= 1'b1;
		tick();
		scl_line <= 1'b0;
		tick();
	endtask : start_cond
	task automatic stop_cond;
		sda_low <= 1'b1;
		tick();
		scl_line <= 1'b1;
		tick();
		sda_low <= 1'b0;
		tick();
	endtask : stop_cond
	task automatic write_reg(input logic [7:0] ofs, input logic [7:0] data);
		start_cond();
		send_byte({DEV_ADDR, 1'b0});
		send_byte(ofs);
		send_byte(data);
		stop_cond();
	endtask : write_reg
	// single-byte read ended by a nack, as the port expects
	task automatic read_reg(input logic [7:0] ofs, output logic [7:0] data);
		start_cond();
		send_byte({DEV_ADDR, 1'b0});
		send_byte(ofs);
		start_cond();
		send_byte({DEV_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) begin
			get_bit(data[i]);
		end
		put_bit(1'b1);
		stop_cond();
	endtask : read_reg
endmodule : gpev_i2c_host

// ==== verification/gpio_event_irq_status_and_pld_tb_top.sv ====
// self-checking bench for the event flags, interrupt pin and lookup-table outputs
module gpio_event_irq_status_and_pld_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk;
	logic        resetn;
	logic        scl_line;
	logic        host_sda_low;
	logic        sda_drv;
	logic        sda_oe;
	logic        irq_out_n_drv;
	logic        irq_out_n_oe;
	logic [7:0]  io_pin;
	logic [7:0]  irq_mask;
	logic [7:0]  pld_out;
	logic [7:0]  pld_oe;
	logic [7:0]  rd;
	logic [15:0] edge_select_cfg;
	int          fails = 0;
	int          n_compared = 0;
	// open-drain wires resolved with their pull-ups
	wire logic sda_line = ~(host_sda_low | (sda_oe & ~sda_drv));
	wire logic irq_level = ~(irq_out_n_oe & ~irq_out_n_drv);
	gpev_top i_gpev_top (.mclk(mclk), .resetn(resetn), .scl_line(scl_line),
		.sda_line(sda_line), .sda_drv(sda_drv), .sda_oe(sda_oe), .io_pin(io_pin),
		.edge_select_cfg(edge_select_cfg), .irq_mask(irq_mask),
		.irq_out_n_drv(irq_out_n_drv), .irq_out_n_oe(irq_out_n_oe),
		.pld_out(pld_out), .pld_oe(pld_oe));
	gpev_i2c_host i_gpev_i2c_host (.mclk(mclk), .sda_in(sda_line), .scl_line(scl_line),
		.sda_low(host_sda_low));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic expect_reg(input logic [7:0] ofs, input logic [7:0] exp);
		i_gpev_i2c_host.read_reg(ofs, rd);
		check($sformatf("register %h", ofs), rd, exp);
	endtask : expect_reg
	// covers the pin filter plus the registered outputs
	task automatic settle;
		repeat (10) @(posedge mclk);
	endtask : settle
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop
	task automatic t_reset;
		expect_reg(gpev_pkg::OFS_IRQ_SRC, 8'h00);
		expect_reg(gpev_pkg::OFS_EVENT, 8'h00);
		expect_reg(gpev_pkg::OFS_FN_MODE, 8'h00);
		expect_reg(gpev_pkg::OFS_TABLE0, 8'h00);
		check("irq pin", {7'h00, irq_level}, 8'h01);
		$display("done reset values");
	endtask : t_reset
	// io1 masked: its event is flagged but raises no interrupt source
	task automatic t_events;
		edge_select_cfg <= {12'h000, gpev_pkg::EDGE_RISE, gpev_pkg::EDGE_RISE};
		irq_mask <= 8'hFE;
		settle();
		io_pin <= 8'h03;
		settle();
		check("irq pin", {7'h00, irq_level}, 8'h00);
		expect_reg(gpev_pkg::OFS_EVENT, 8'h03);
		expect_reg(gpev_pkg::OFS_IRQ_SRC, 8'h01);
		i_gpev_i2c_host.write_reg(gpev_pkg::OFS_IRQ_SRC, 8'h00);
		expect_reg(gpev_pkg::OFS_IRQ_SRC, 8'h01);
		i_gpev_i2c_host.write_reg(gpev_pkg::OFS_IRQ_SRC, 8'h01);
		expect_reg(gpev_pkg::OFS_EVENT, 8'h02);
		check("irq pin", {7'h00, irq_level}, 8'h01);
		io_pin <= 8'h02;
		settle();
		io_pin <= 8'h03;
		settle();
		i_gpev_i2c_host.write_reg(gpev_pkg::OFS_EVENT, 8'h03);
		expect_reg(gpev_pkg::OFS_IRQ_SRC, 8'h00);
		expect_reg(gpev_pkg::OFS_EVENT, 8'h00);
		$display("done events");
	endtask : t_events
	task automatic t_sense;
		edge_select_cfg <= {10'h000, gpev_pkg::EDGE_FALL, 4'h0};
		irq_mask <= 8'h00;
		io_pin <= 8'h07;
		settle();
		io_pin <= 8'h03;
		settle();
		expect_reg(gpev_pkg::OFS_IRQ_SRC, 8'h04);
		expect_reg(gpev_pkg::OFS_EVENT, 8'h04);
		edge_select_cfg <= {10'h000, gpev_pkg::EDGE_BOTH, 4'h0};
		settle();
		edge_select_cfg <= 16'h0000;
		expect_reg(gpev_pkg::OFS_EVENT, 8'h00);
		expect_reg(gpev_pkg::OFS_IRQ_SRC, 8'h00);
		check("irq pin", {7'h00, irq_level}, 8'h01);
		$display("done sense change");
	endtask : t_sense
	task automatic t_pld;
		logic [7:0] t0;
		logic [7:0] t1;
		t0 = 8'hA5;
		t1 = 8'h3C;
		i_gpev_i2c_host.write_reg(gpev_pkg::OFS_TABLE0, t0);
		i_gpev_i2c_host.write_reg(gpev_pkg::OFS_TABLE1, t1);
		// every upper code, reserved bits 3:2 kept at zero
		for (int m = 0; m < 4; m++) begin
			i_gpev_i2c_host.write_reg(gpev_pkg::OFS_FN_MODE, {2'h0, 2'(m), 4'h0});
			settle();
			check("upper enables", {6'h00, pld_oe[7:6]},
				(m == 1) ? 8'h01 : (m == 2) ? 8'h02 : 8'h00);
			// io6:4 still at 011 from the two-to-one sweep when code 10 is tried
			check("io7 decode", {7'h00, pld_out[7]}, {7'h00, (m == 2) ? t1[3] : 1'b0});
			for (int k = 0; k < 4 && m == 1; k++) begin
				io_pin <= {2'h0, 2'(k), 4'h0};
				settle();
				check("io6 decode", {7'h00, pld_out[6]}, {7'h00, t0[{1'b1, 2'(k)}]});
			end
		end
		i_gpev_i2c_host.write_reg(gpev_pkg::OFS_FN_MODE, {6'h00, gpev_pkg::FN_THREE_ONE});
		expect_reg(gpev_pkg::OFS_FN_MODE, 8'h02);
		for (int k = 0; k < 8; k++) begin
			io_pin <= {4'h0, k[2], 1'b0, k[1], k[0]};
			settle();
			check("io2 decode", {6'h00, pld_oe[2], pld_out[2]}, {6'h00, 1'b1, t1[k]});
		end
		i_gpev_i2c_host.write_reg(gpev_pkg::OFS_FN_MODE, 8'h00);
		settle();
		check("enables off", pld_oe, 8'h00);
		$display("done lookup tables");
	endtask : t_pld
	initial begin
		resetn = 1'b0;
		io_pin = 8'h00;
		irq_mask = 8'hFF;
		edge_select_cfg = 16'h0000;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		settle();
		t_reset();
		t_events();
		t_sense();
		t_pld();
		check("host acks", i_gpev_i2c_host.ack_misses[7:0], 8'h00);
		report_and_stop();
	end
	// cuts a hung run short
	initial begin
		repeat (100000) @(posedge mclk);
		fails++;
		report_and_stop();
	end
endmodule : gpio_event_irq_status_and_pld_tb_top
